// ### src/uo_protect.sv
/*
  Underspeed and excitation overcurrent supervisor of an alternator
  voltage regulator: threshold derivation, V/f setpoint scaling,
  excitation limit loop, alarm mask and indicator pattern.
  Assumes frequency, temperature estimate and pot readings arrive
  synchronous to CLK and that CTRL_TICK pulses are at least 52 clocks
  apart.
*/
`timescale 1ns/100ps
module uo_protect
  import uo_protect_pkg::*;
#(
  parameter int unsigned SLOW_HALF = LED_SLOW_MS * (CLK_HZ / 1000),
  parameter int unsigned MID_HALF  = LED_MID_MS * (CLK_HZ / 1000),
  parameter int unsigned FAST_HALF = LED_FAST_MS * (CLK_HZ / 1000)
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CTRL_TICK,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic        REG_GUI,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic [15:0]      REG_RDATA,
  output logic             REG_RVALID,
  input  wire logic [15:0] FREQ_MEAS,
  input  wire logic [15:0] FREQ_THRESHOLD_POT,
  input  wire logic [15:0] CURRENT_LIMIT_POT,
  input  wire logic        OPTION_JUMPER_60,
  input  wire logic [15:0] EXCITATION_TEMPERATURE_ESTIMATE,
  input  wire logic [15:0] VSET_NOMINAL,
  output logic [15:0]      VSET_OUT,
  output logic [15:0]      EXC_CUT,
  output logic             ALARM_EXC,
  output logic             ALARM_SPEED,
  output logic             LED
);

  localparam int unsigned NW = 48;
  localparam int unsigned DW = 32;
  localparam int unsigned LW = $clog2(SLOW_HALF + 1);

  generate
    if (FAST_HALF < 1 || FAST_HALF >= MID_HALF || MID_HALF >= SLOW_HALF)
    begin : g_bad
      $error("uo_protect: blink half periods must rise fast<mid<slow");
    end
  endgenerate

  logic [15:0]     thr_param_r;
  logic [15:0]     limit_param_r;
  logic [15:0]     slope_param_r;
  logic [15:0]     gain_param_r;
  logic [3:0]      settings_r;
  logic [15:0]     thr_r;
  logic            speed_alarm_r;
  logic            exc_alarm_r;
  logic [INTEG_W-1:0] integ_r;
  logic [15:0]     reduction_r;
  logic [15:0]     vset_nxt;
  logic [LW-1:0]   blink_cnt_r;
  logic            led_r;
  logic [15:0]     p_eff;
  logic [15:0]     p_clip;
  logic            sel60;
  logic [15:0]     f_lo;
  logic [15:0]     f_mid;
  logic [15:0]     f_hi;
  logic [31:0]     up_term;
  logic [31:0]     lo_term;
  logic [15:0]     thr_nxt;
  logic [15:0]     limit_eff;
  logic [15:0]     alarm_mask;
  logic [16:0]     temp_diff;
  logic [31:0]     integ_step;
  logic [INTEG_W:0] integ_sum;
  logic [NW-1:0]   div_num;
  logic [DW-1:0]   div_den;
  logic            div_start;
  logic            div_done;
  logic [NW-1:0]   div_quot;
  logic [LW-1:0]   blink_half;
  logic            wr_thr_or_slope;

  // effective threshold parameter, pot in place of the written value
  assign p_eff = settings_r[SET_FREQ_POT_EN] ? FREQ_THRESHOLD_POT
                                              : thr_param_r;
  assign p_clip = (p_eff > PARAM_TOP) ? PARAM_TOP : p_eff;
  assign sel60 = settings_r[SET_SEL_60] |
                 (settings_r[SET_JUMPER_EN] & OPTION_JUMPER_60);

  always_comb begin
    f_lo  = sel60 ? F60_LO  : F50_LO;
    f_mid = sel60 ? F60_MID : F50_MID;
    f_hi  = sel60 ? F60_HI  : F50_HI;
    lo_term = (32'(p_clip) * 32'(f_mid - f_lo)) >> PARAM_MID_SHIFT;
    up_term = (32'(p_clip - PARAM_MID) * 32'(f_hi - f_mid))
              / 32'(PARAM_TOP - PARAM_MID);
    if (p_clip <= PARAM_MID) begin
      thr_nxt = f_lo + lo_term[15:0];
    end else begin
      thr_nxt = f_mid + up_term[15:0];
    end
  end

  assign limit_eff = settings_r[SET_AMP_POT_EN] ? CURRENT_LIMIT_POT
                                                : limit_param_r;

  assign wr_thr_or_slope = REG_WR & REG_GUI &
                           ((REG_ADDR == LOC_THR_PARAM) ||
                            (REG_ADDR == LOC_SLOPE_PARAM));

  // parameter locations
  always_ff @(posedge CLK) begin
    if (RST) begin
      thr_param_r   <= THR_PARAM_RST;
      limit_param_r <= LIMIT_PARAM_RST;
      slope_param_r <= SLOPE_PARAM_RST;
      gain_param_r  <= GAIN_PARAM_RST;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        LOC_THR_PARAM:   thr_param_r   <= REG_WDATA;
        LOC_LIMIT_PARAM: limit_param_r <= REG_WDATA;
        LOC_SLOPE_PARAM: slope_param_r <= REG_WDATA;
        LOC_GAIN_PARAM:  gain_param_r  <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // settings bits; a settings-interface write of the threshold or slope parameter drops the frequency pot
  always_ff @(posedge CLK) begin
    if (RST) begin
      settings_r <= SETTINGS_RST;
    end else if (wr_thr_or_slope) begin
      settings_r[SET_FREQ_POT_EN] <= 1'b0;
    end else if (REG_WR && REG_ADDR == LOC_SETTINGS) begin
      settings_r <= REG_WDATA[3:0];
    end
  end

  // underspeed comparison on each control tick
  always_ff @(posedge CLK) begin
    if (RST) begin
      thr_r         <= F50_MID;
      speed_alarm_r <= 1'b0;
    end else if (CTRL_TICK) begin
      thr_r         <= thr_nxt;
      speed_alarm_r <= (FREQ_MEAS < thr_nxt);
    end
  end

  // reduction = nominal * (thr - f) * slope / (thr * unit slope)
  assign div_start = CTRL_TICK & (FREQ_MEAS < thr_nxt)
                     & (slope_param_r != '0);
  assign div_num = NW'(VSET_NOMINAL) * NW'(thr_nxt - FREQ_MEAS)
                   * NW'(slope_param_r);
  assign div_den = DW'(thr_nxt) * DW'(SLOPE_UNIT);

  uo_divider #(
    .NW (NW),
    .DW (DW)
  ) uo_divider_i (
    .clk   (CLK),
    .rst   (RST),
    .start (div_start),
    .num   (div_num),
    .den   (div_den),
    .busy  (),
    .done  (div_done),
    .quot  (div_quot)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      reduction_r <= '0;
    end else if (CTRL_TICK && !div_start) begin
      reduction_r <= '0;
    end else if (div_done) begin
      reduction_r <= (div_quot > NW'(VSET_NOMINAL)) ? VSET_NOMINAL
                     : div_quot[15:0];
    end
  end

  // excitation limit loop, integral action only
  assign temp_diff = (EXCITATION_TEMPERATURE_ESTIMATE >= limit_eff)
    ? 17'(EXCITATION_TEMPERATURE_ESTIMATE - limit_eff)
    : 17'(limit_eff - EXCITATION_TEMPERATURE_ESTIMATE);
  assign integ_step = (32'(temp_diff) * 32'(gain_param_r))
                      >> INTEG_SHIFT;

  always_comb begin
    if (EXCITATION_TEMPERATURE_ESTIMATE >= limit_eff) begin
      integ_sum = (INTEG_W+1)'(integ_r) + (INTEG_W+1)'(integ_step);
    end else if ((INTEG_W+1)'(integ_step) >= (INTEG_W+1)'(integ_r)) begin
      integ_sum = '0;
    end else begin
      integ_sum = (INTEG_W+1)'(integ_r) - (INTEG_W+1)'(integ_step);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      integ_r     <= '0;
      exc_alarm_r <= 1'b0;
    end else if (CTRL_TICK) begin
      integ_r <= integ_sum[INTEG_W] ? '1 : integ_sum[INTEG_W-1:0];
      // alarm holds until the integrator has wound back to zero
      exc_alarm_r <= (EXCITATION_TEMPERATURE_ESTIMATE >= limit_eff) ||
                     (integ_sum != '0);
    end
  end

  // setpoint out: V/f reduction, then excitation cut
  always_comb begin
    if (32'(reduction_r) + 32'(integ_r[INTEG_W-1:INTEG_W-16])
        >= 32'(VSET_NOMINAL)) begin
      vset_nxt = '0;
    end else begin
      vset_nxt = VSET_NOMINAL - reduction_r
                 - integ_r[INTEG_W-1:INTEG_W-16];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      VSET_OUT <= '0;
      EXC_CUT  <= '0;
    end else begin
      VSET_OUT <= vset_nxt;
      EXC_CUT  <= integ_r[INTEG_W-1:INTEG_W-16];
    end
  end

  assign ALARM_EXC   = exc_alarm_r;
  assign ALARM_SPEED = speed_alarm_r;

  always_comb begin
    alarm_mask = '0;
    alarm_mask[ALM_EXC_BIT]   = exc_alarm_r;
    alarm_mask[ALM_SPEED_BIT] = speed_alarm_r;
    alarm_mask[ALM_NONE_BIT]  = ~(exc_alarm_r | speed_alarm_r);
  end

  // indicator: slow blink when healthy, faster with alarms
  always_comb begin
    if (speed_alarm_r) begin
      blink_half = LW'(FAST_HALF);
    end else if (exc_alarm_r) begin
      blink_half = LW'(MID_HALF);
    end else begin
      blink_half = LW'(SLOW_HALF);
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      blink_cnt_r <= '0;
      led_r       <= 1'b0;
    end else if (blink_cnt_r + LW'(1) >= blink_half) begin
      blink_cnt_r <= '0;
      led_r       <= ~led_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + LW'(1);
    end
  end

  assign LED = led_r;

  // read port, data one clock after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RDATA  <= '0;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        unique case (REG_ADDR)
          LOC_THR_PARAM:   REG_RDATA <= thr_param_r;
          LOC_LIMIT_PARAM: REG_RDATA <= limit_param_r;
          LOC_SLOPE_PARAM: REG_RDATA <= slope_param_r;
          LOC_GAIN_PARAM:  REG_RDATA <= gain_param_r;
          LOC_EFF_THR:     REG_RDATA <= p_clip;
          LOC_ALARMS:      REG_RDATA <= alarm_mask;
          LOC_TEMP_EST:    REG_RDATA <= EXCITATION_TEMPERATURE_ESTIMATE;
          LOC_EFF_LIMIT:   REG_RDATA <= limit_eff;
          LOC_SETTINGS:    REG_RDATA <= {12'h000, settings_r};
          default:         REG_RDATA <= '0;
        endcase
      end
    end
  end

endmodule : uo_protect

// ### src/uo_protect_pkg.sv
/*
  Constants for the underspeed and excitation overcurrent supervisor:
  location map, field positions, reset values, frequency breakpoints
  and indicator timing. Assumes nothing of its surroundings.
*/
package uo_protect_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;

  // locations of the host terminal
  localparam logic [7:0] LOC_THR_PARAM   = 8'h15;
  localparam logic [7:0] LOC_LIMIT_PARAM = 8'h16;
  localparam logic [7:0] LOC_SLOPE_PARAM = 8'h17;
  localparam logic [7:0] LOC_GAIN_PARAM  = 8'h1C;
  localparam logic [7:0] LOC_EFF_THR     = 8'h22;
  localparam logic [7:0] LOC_ALARMS      = 8'h26;
  localparam logic [7:0] LOC_TEMP_EST    = 8'h2D;
  localparam logic [7:0] LOC_EFF_LIMIT   = 8'h37;
  localparam logic [7:0] LOC_SETTINGS    = 8'h40;

  // reset values
  localparam logic [15:0] THR_PARAM_RST   = 16'h4000;
  localparam logic [15:0] LIMIT_PARAM_RST = 16'h7FFF;
  localparam logic [15:0] SLOPE_PARAM_RST = 16'h2328;
  localparam logic [15:0] GAIN_PARAM_RST  = 16'h0400;
  localparam logic [3:0]  SETTINGS_RST    = 4'h0;

  // settings location fields
  localparam int unsigned SET_FREQ_POT_EN = 0;
  localparam int unsigned SET_AMP_POT_EN  = 1;
  localparam int unsigned SET_JUMPER_EN   = 2;
  localparam int unsigned SET_SEL_60      = 3;

  // alarm mask fields
  localparam int unsigned ALM_EXC_BIT   = 4;
  localparam int unsigned ALM_SPEED_BIT = 5;
  localparam int unsigned ALM_NONE_BIT  = 11;

  // threshold parameter scale
  localparam logic [15:0] PARAM_MID   = 16'h4000;
  localparam logic [15:0] PARAM_TOP   = 16'h7FFF;
  localparam int unsigned PARAM_MID_SHIFT = 14;

  // frequency breakpoints in units of 0.01 Hz
  localparam logic [15:0] F50_LO  = 16'h0FA0;
  localparam logic [15:0] F50_MID = 16'h1194;
  localparam logic [15:0] F50_HI  = 16'h1388;
  localparam logic [15:0] F60_LO  = 16'h12C0;
  localparam logic [15:0] F60_MID = 16'h1518;
  localparam logic [15:0] F60_HI  = 16'h1770;

  // slope value that makes voltage strictly proportional to frequency
  localparam logic [15:0] SLOPE_UNIT = 16'h2328;

  // excitation integrator
  localparam int unsigned INTEG_W     = 24;
  localparam int unsigned INTEG_SHIFT = 12;

  // indicator half periods
  localparam int unsigned LED_SLOW_MS = 500;
  localparam int unsigned LED_MID_MS  = 250;
  localparam int unsigned LED_FAST_MS = 100;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN  = 2'b10
  } div_state_type;

endpackage : uo_protect_pkg

// ### src/uo_divider.sv
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes start is only raised while busy is low.
*/
`timescale 1ns/100ps
module uo_divider
  import uo_protect_pkg::*;
#(
  parameter int unsigned NW = 48,
  parameter int unsigned DW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               busy,
  output logic               done,
  output logic [NW-1:0]      quot
);

  localparam int unsigned CW = $clog2(NW + 1);

  generate
    if (NW < 2 || DW < 1) begin : g_bad
      $error("uo_divider: widths too small");
    end
  endgenerate

  div_state_type   state_r;
  logic [NW-1:0]   q_r;
  logic [DW:0]     rem_r;
  logic [DW-1:0]   den_r;
  logic [CW-1:0]   cnt_r;
  logic [DW:0]     trial;
  logic [DW:0]     den_ext;

  assign den_ext = {1'b0, den_r};
  assign trial   = {rem_r[DW-1:0], q_r[NW-1]};

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= DIV_IDLE;
      q_r     <= '0;
      rem_r   <= '0;
      den_r   <= '0;
      cnt_r   <= '0;
      done    <= 1'b0;
      quot    <= '0;
    end else begin
      done <= 1'b0;
      unique case (state_r)
        DIV_IDLE: begin
          if (start) begin
            q_r     <= num;
            rem_r   <= '0;
            den_r   <= den;
            cnt_r   <= CW'(NW);
            state_r <= DIV_RUN;
          end
        end
        DIV_RUN: begin
          if (trial >= den_ext) begin
            rem_r <= trial - den_ext;
            q_r   <= {q_r[NW-2:0], 1'b1};
          end else begin
            rem_r <= trial;
            q_r   <= {q_r[NW-2:0], 1'b0};
          end
          cnt_r <= cnt_r - CW'(1);
          if (cnt_r == CW'(1)) begin
            state_r <= DIV_IDLE;
            done    <= 1'b1;
            // a zero divisor saturates instead of giving garbage
            quot    <= (den_r == '0) ? '1 :
                       ((trial >= den_ext) ? {q_r[NW-2:0], 1'b1}
                                           : {q_r[NW-2:0], 1'b0});
          end
        end
        default: state_r <= DIV_IDLE;
      endcase
    end
  end

  assign busy = (state_r == DIV_RUN);

endmodule : uo_divider

// ### tb/uo_protect_assertions.sv
/*
  Port checker of the supervisor: read answer, alarm timing,
  setpoint bounds and indicator rate.
  Assumes one clock CLK and synchronous active high RST.
*/
`timescale 1ns/100ps
module uo_protect_assertions
  import uo_protect_pkg::*;
#(
  parameter int unsigned SLOW_HALF = 40,
  parameter int unsigned MID_HALF  = 20,
  parameter int unsigned FAST_HALF = 8
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        CTRL_TICK,
  input wire logic        REG_RD,
  input wire logic        REG_RVALID,
  input wire logic [15:0] FREQ_MEAS,
  input wire logic [15:0] VSET_NOMINAL,
  input wire logic [15:0] VSET_OUT,
  input wire logic [15:0] EXC_CUT,
  input wire logic        ALARM_EXC,
  input wire logic        ALARM_SPEED,
  input wire logic        LED
);
  int unsigned led_cnt_r;
  int unsigned spd_cnt_r;

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  // cycles since the indicator last changed
  always_ff @(posedge CLK) begin
    if (RST || $changed(LED)) led_cnt_r <= 0;
    else led_cnt_r <= led_cnt_r + 1;
  end

  always_ff @(posedge CLK) begin
    if (RST || !ALARM_SPEED) spd_cnt_r <= 0;
    else spd_cnt_r <= spd_cnt_r + 1;
  end

  a_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read strobe got no valid");
  a_valid_cause: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("valid without a read");
  a_alarm_hold: assert property (
    !CTRL_TICK |=> $stable({ALARM_SPEED, ALARM_EXC}))
    else $error("alarm moved between ticks");
  a_speed_low: assert property (
    CTRL_TICK && FREQ_MEAS < F50_LO |=> ALARM_SPEED)
    else $error("underspeed alarm missing");
  a_speed_high: assert property (
    CTRL_TICK && FREQ_MEAS >= F60_HI |=> !ALARM_SPEED)
    else $error("underspeed alarm above any threshold");
  a_cut_alarm: assert property (
    EXC_CUT != 16'h0000 |-> ALARM_EXC || $past(ALARM_EXC))
    else $error("excitation cut without alarm");
  a_vset_normal: assert property (
    (!ALARM_SPEED && !ALARM_EXC) [*2] |=>
      VSET_OUT == $past(VSET_NOMINAL))
    else $error("setpoint not nominal without alarm");
  a_vset_bound: assert property (
    1'b1 |=> VSET_OUT <= $past(VSET_NOMINAL))
    else $error("setpoint above nominal");
  a_led_fast: assert property (
    spd_cnt_r > SLOW_HALF + 2 |-> led_cnt_r <= FAST_HALF + 1)
    else $error("indicator not blinking fast");
endmodule : uo_protect_assertions

bind uo_protect uo_protect_assertions #(
  .SLOW_HALF(SLOW_HALF),
  .MID_HALF (MID_HALF),
  .FAST_HALF(FAST_HALF)
) uo_protect_assertions_i (
  .CLK         (CLK),
  .RST         (RST),
  .CTRL_TICK   (CTRL_TICK),
  .REG_RD      (REG_RD),
  .REG_RVALID  (REG_RVALID),
  .FREQ_MEAS   (FREQ_MEAS),
  .VSET_NOMINAL(VSET_NOMINAL),
  .VSET_OUT    (VSET_OUT),
  .EXC_CUT     (EXC_CUT),
  .ALARM_EXC   (ALARM_EXC),
  .ALARM_SPEED (ALARM_SPEED),
  .LED         (LED)
);

// ### tb/uo_alternator.sv
/*
  Alternator model: control ticks, measured frequency and a lagging
  rotor temperature that the excitation cut pulls down.
  Assumes frequency and load are set by the bench.
*/
`timescale 1ns/100ps
module uo_alternator #(
  parameter int unsigned TICK_GAP = 60
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] freq_cmd,
  input  wire logic [15:0] load_cmd,
  input  wire logic [15:0] exc_cut,
  output logic             ctrl_tick,
  output logic [15:0]      freq_meas,
  output logic [15:0]      temp_est
);
  int unsigned gap_r;
  int          temp_r;
  int          tgt;

  always_ff @(posedge clk) begin
    if (rst || ctrl_tick) gap_r <= 0;
    else gap_r <= gap_r + 1;
  end

  // first order lag towards load heat minus what the cut removes
  assign tgt = int'(load_cmd) - 16 * int'(exc_cut);
  always_ff @(posedge clk) begin
    if (rst) temp_r <= 0;
    else if (ctrl_tick) temp_r <= temp_r + ((tgt < 0 ? 0 : tgt) - temp_r) / 4;
  end

  assign ctrl_tick = (gap_r == TICK_GAP - 1);
  assign freq_meas = freq_cmd;
  assign temp_est  = 16'(temp_r);
endmodule : uo_alternator

// ### tb/uo_protect_test.sv
/*
  Self-checking bench of the supervisor with the alternator model.
  Assumes package, design, model and checker are compiled first.
*/
`timescale 1ns/100ps
module uo_protect_test
  import uo_protect_pkg::*;
;
  localparam logic [15:0] NOM = 16'h03E8;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        reg_gui = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] freq_cmd = 16'h1388;
  logic [15:0] load_cmd = 16'h0000;
  logic [15:0] hz_pot = 16'h0000;
  logic [15:0] amp_pot = 16'h0000;
  logic        jumper_60 = 1'b0;
  logic [15:0] reg_rdata, freq_meas, temp_est, vset_out, exc_cut;
  logic        reg_rvalid, ctrl_tick, alarm_exc, alarm_speed, led;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;

  uo_protect #(.SLOW_HALF(40), .MID_HALF(20), .FAST_HALF(8)) uo_protect_i (
    .CLK(clk), .RST(rst), .CTRL_TICK(ctrl_tick), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_GUI(reg_gui), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .FREQ_MEAS(freq_meas), .FREQ_THRESHOLD_POT(hz_pot),
    .CURRENT_LIMIT_POT(amp_pot), .OPTION_JUMPER_60(jumper_60),
    .EXCITATION_TEMPERATURE_ESTIMATE(temp_est), .VSET_NOMINAL(NOM),
    .VSET_OUT(vset_out), .EXC_CUT(exc_cut), .ALARM_EXC(alarm_exc),
    .ALARM_SPEED(alarm_speed), .LED(led));

  uo_alternator uo_alternator_i (
    .clk(clk), .rst(rst), .freq_cmd(freq_cmd), .load_cmd(load_cmd),
    .exc_cut(exc_cut), .ctrl_tick(ctrl_tick), .freq_meas(freq_meas),
    .temp_est(temp_est));

  always #20 clk = ~clk;

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [15:0] d, logic g);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_gui = g;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_gui = 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [15:0] exp, string what);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rvalid", {15'h0, reg_rvalid}, 16'h0001);
    chk(what, reg_rdata, exp);
  endtask : rd

  task automatic tk(int n);
    repeat (n) @(posedge clk iff ctrl_tick);
    @(negedge clk);
  endtask : tk

  function automatic logic [15:0] thr(logic [15:0] p, logic s60);
    int lo, mid, hi;
    lo = s60 ? F60_LO : F50_LO;
    mid = s60 ? F60_MID : F50_MID;
    hi = s60 ? F60_HI : F50_HI;
    if (p <= PARAM_MID) return 16'(lo + ((int'(p) * (mid - lo)) >> 14));
    return 16'(mid + (int'(p) - 16384) * (hi - mid) / 16383);
  endfunction : thr

  task automatic t_regs();
    rd(LOC_THR_PARAM, THR_PARAM_RST, "thr");
    rd(LOC_LIMIT_PARAM, LIMIT_PARAM_RST, "limit");
    rd(LOC_SLOPE_PARAM, 16'h2328, "slope");
    rd(LOC_SETTINGS, 16'h0000, "settings");
    rd(LOC_ALARMS, 16'h0800, "no alarm");
    rd(8'h7F, 16'h0000, "unmapped");
    wr(LOC_EFF_THR, 16'h1234, 1'b0);
    rd(LOC_EFF_THR, THR_PARAM_RST, "ro thr");
    rd(LOC_GAIN_PARAM, GAIN_PARAM_RST, "gain");
    wr(LOC_GAIN_PARAM, 16'h4000, 1'b0);
    rd(LOC_GAIN_PARAM, 16'h4000, "gain wr");
    $display("t_regs done");
  endtask : t_regs

  task automatic t_thr();
    logic [15:0] p [4] = '{16'h0000, 16'h2000, 16'h4000, 16'h7FFF};
    logic [15:0] s [3] = '{16'h0000, 16'h0008, 16'h0004};
    logic [15:0] t;
    for (int m = 0; m < 3; m++) begin
      jumper_60 = (m == 2);
      wr(LOC_SETTINGS, s[m], 1'b0);
      for (int i = 0; i < 4; i++) begin
        wr(LOC_THR_PARAM, p[i], 1'b0);
        t = thr(p[i], m != 0);
        freq_cmd = t - 16'h0001;
        tk(1);
        chk("below", {15'h0, alarm_speed}, 16'h0001);
        freq_cmd = t;
        tk(1);
        chk("at", {15'h0, alarm_speed}, 16'h0000);
      end
    end
    jumper_60 = 1'b0;
    $display("t_thr done");
  endtask : t_thr

  task automatic t_pot();
    wr(LOC_THR_PARAM, 16'h4000, 1'b0);
    wr(LOC_SETTINGS, 16'h0001, 1'b0);
    freq_cmd = 16'h0F9F;
    tk(1);
    rd(LOC_EFF_THR, 16'h0000, "pot thr");
    chk("pot low", {15'h0, alarm_speed}, 16'h0001);
    hz_pot = 16'h9C40;
    tk(1);
    rd(LOC_EFF_THR, 16'h7FFF, "pot clip");
    wr(LOC_THR_PARAM, 16'h4000, 1'b0);
    rd(LOC_SETTINGS, 16'h0001, "plain wr");
    wr(LOC_SLOPE_PARAM, 16'h2328, 1'b1);
    rd(LOC_SETTINGS, 16'h0000, "gui wr");
    tk(1);
    rd(LOC_EFF_THR, 16'h4000, "param thr");
    $display("t_pot done");
  endtask : t_pot

  task automatic t_vf();
    logic [15:0] sl [4] = '{16'h2328, 16'h4650, 16'h0000, 16'hFFFF};
    logic [15:0] ex [4] = '{16'h0320, 16'h0258, 16'h03E8, 16'h0000};
    int          n;
    logic        l0;
    freq_cmd = 16'h0E10;
    for (int i = 0; i < 4; i++) begin
      wr(LOC_SLOPE_PARAM, sl[i], 1'b0);
      tk(2);
      chk("vset vf", vset_out, ex[i]);
    end
    rd(LOC_ALARMS, 16'h0020, "alarm 6");
    // half period of the indicator while underspeed is active
    @(led);
    l0 = led;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (led !== l0) break;
    end
    chk("blink fast", 16'(n), 16'h0008);
    freq_cmd = 16'h1388;
    tk(2);
    chk("speed off", {15'h0, alarm_speed}, 16'h0000);
    chk("vset back", vset_out, NOM);
    rd(LOC_ALARMS, 16'h0800, "clear");
    $display("t_vf done");
  endtask : t_vf

  task automatic t_exc();
    wr(LOC_LIMIT_PARAM, 16'h03E8, 1'b0);
    load_cmd = 16'h0BB8;
    for (int n = 0; n < 40 && alarm_exc !== 1'b1; n++) tk(1);
    tk(2);
    rd(LOC_TEMP_EST, temp_est, "temp");
    chk("alarm 5", {15'h0, alarm_exc}, 16'h0001);
    chk("cut", {15'h0, exc_cut != 16'h0000}, 16'h0001);
    chk("vset low", {15'h0, vset_out < NOM}, 16'h0001);
    rd(LOC_ALARMS, 16'h0010, "alarm 5 mask");
    rd(LOC_EFF_LIMIT, 16'h03E8, "limit");
    amp_pot = 16'h07D0;
    wr(LOC_SETTINGS, 16'h0002, 1'b0);
    tk(1);
    rd(LOC_EFF_LIMIT, 16'h07D0, "pot limit");
    wr(LOC_SETTINGS, 16'h0000, 1'b0);
    load_cmd = 16'h0000;
    for (int n = 0; n < 200 && alarm_exc !== 1'b0; n++) tk(1);
    chk("alarm 5 off", {15'h0, alarm_exc}, 16'h0000);
    tk(1);
    chk("vset nominal", vset_out, NOM);
    $display("t_exc done");
  endtask : t_exc

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_thr();
    t_pot();
    t_vf();
    t_exc();
    test_done();
  end
endmodule : uo_protect_test
